/* design/timer8_wave.sv */
// 8-bit timer/counter with one compare channel and waveform output
// Notes on behaviour
// - Mode field selects four modes and TOP
// - Compare writes immediate or buffered by mode
// - Fast PWM setting 1 toggles on match
// - Phase PWM counts up then down
// - Phase PWM holds MAX one tick
// - Phase PWM setting 2 clears up, sets down
// - Phase PWM overflow flag at BOTTOM
// - Compare BOTTOM/MAX give constant phase PWM levels
// - Leaving MAX applies up-match result at MAX
// - Missed up-match still applied at MAX
// - Pin driven only when direction is output
// - Synchronous, tick is a clock enable
// - Phase PWM period 510 ticks
// - Force strobe works only in non-PWM modes
// - Force strobe acts like a compare match
// - Force sets no flag, clears no counter
// - Force strobe reads back as zero
// - Control A field layout, reset zero
// - Clock select chooses tick source
// - Non-PWM output settings: off, toggle, clear, set
`timescale 1ns/1ns
module timer8_wave (
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Register port
	input wire logic [1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	output logic [7:0] rdata_out,
	// External clock source and pin direction
	input wire logic ext_clock_in,
	input wire logic pin_dir_out_in,
	// Waveform pin and flags
	output logic wave_output_pin_out,
	output logic wave_output_pin_oe_out,
	output logic overflow_flag_out,
	output logic compare_match_flag_out
);
	import timer8_pkg::*;

	typedef struct packed {
		logic wave_mode_low;
		logic [1:0] compare_out_mode;
		logic wave_mode_high;
		logic [2:0] clock_source_sel;
		logic [7:0] count_value;
		logic [7:0] compare_value;
		logic [7:0] compare_buffer;
		logic count_down;
		logic block_match;
		logic wave_output;
		logic overflow_flag;
		logic compare_match_flag;
		logic [7:0] rdata;
		logic pin;
		logic pin_oe;
	} timer_state_t;

	timer_state_t state;
	timer_state_t next_state;
	logic timer_tick;
	wave_mode_t mode;

	// tick from prescaler used as enable
	timer8_prescaler prescaler (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.clock_source_sel_in(state.clock_source_sel),
		.ext_clock_in(ext_clock_in),
		.timer_tick_out(timer_tick)
	);

	assign mode = wave_mode_t'({state.wave_mode_high, state.wave_mode_low});

	// Output level after a match in the non-PWM and toggle sense
	function automatic logic match_level(input logic [1:0] com, input logic cur);
		case (com)
			2'h1: match_level = ~cur;
			2'h2: match_level = 1'b0;
			2'h3: match_level = 1'b1;
			default: match_level = cur;
		endcase
	endfunction

	logic is_pwm;
	logic [7:0] active_cmp;
	logic match;
	logic wr_ctrl;
	logic wr_count;
	logic wr_cmp;
	logic wr_flags;
	logic ovf_set;

	always_comb begin
		is_pwm = state.wave_mode_low;
		// PWM modes use the buffered value
		active_cmp = is_pwm ? state.compare_buffer : state.compare_value;
		// equality only counts on ticks, blocked after count write
		match = timer_tick && !state.block_match && (state.count_value == active_cmp);
		wr_ctrl = write_in && (addr_in == REG_CONTROL_A);
		wr_count = write_in && (addr_in == REG_COUNT);
		wr_cmp = write_in && (addr_in == REG_COMPARE);
		wr_flags = write_in && (addr_in == REG_FLAGS);
	end

	always_comb begin
		next_state = state;
		// Overflow events gathered apart, so a same-cycle clear cannot hide one
		next_state.overflow_flag = 1'b0;
		if (timer_tick) begin
			next_state.block_match = 1'b0;
		end
		// counting advances only on tick enables
		if (timer_tick) begin
			case (mode)
				MODE_NORMAL: begin
					next_state.count_value = state.count_value + 8'h01;
					if (state.count_value == MAX) begin
						next_state.overflow_flag = 1'b1;
					end
				end
				MODE_CLEAR_ON_MATCH: begin
					// TOP is the compare value here
					if (state.count_value == state.compare_value && !state.block_match) begin
						next_state.count_value = BOTTOM;
					end else begin
						next_state.count_value = state.count_value + 8'h01;
					end
					if (state.count_value == MAX) begin
						next_state.overflow_flag = 1'b1;
					end
				end
				MODE_FAST_PWM: begin
					next_state.count_value = state.count_value + 8'h01;
					if (state.count_value == MAX) begin
						next_state.overflow_flag = 1'b1;
						next_state.compare_buffer = state.compare_value;
					end
				end
				default: begin
					// up to MAX, hold one tick, down: 510 ticks
					if (!state.count_down) begin
						if (state.count_value == MAX) begin
							next_state.count_down = 1'b1;
							next_state.count_value = MAX - 8'h01;
						end else begin
							next_state.count_value = state.count_value + 8'h01;
						end
					end else if (state.count_value == BOTTOM) begin
						next_state.count_down = 1'b0;
						next_state.count_value = BOTTOM + 8'h01;
					end else begin
						next_state.count_value = state.count_value - 8'h01;
						if (state.count_value == BOTTOM + 8'h01) begin
							next_state.overflow_flag = 1'b1;
						end
					end
					if (!state.count_down && state.count_value == MAX) begin
						next_state.compare_buffer = state.compare_value;
					end
				end
			endcase
		end

		ovf_set = next_state.overflow_flag;
		next_state.overflow_flag = state.overflow_flag || ovf_set;

		// Waveform generation
		if (timer_tick) begin
			if (match) begin
				// only a real match raises the flag
				next_state.compare_match_flag = 1'b1;
			end
			case (mode)
				MODE_NORMAL, MODE_CLEAR_ON_MATCH: begin
					if (match) begin
						next_state.wave_output = match_level(state.compare_out_mode,
							state.wave_output);
					end
				end
				MODE_FAST_PWM: begin
					if (state.compare_out_mode == 2'h1) begin
						if (match) begin
							next_state.wave_output = ~state.wave_output;
						end
					end else if (state.compare_out_mode[1]) begin
						// Match at MAX ignored, so MAX gives a constant level
						if (match && active_cmp != MAX) begin
							next_state.wave_output = state.compare_out_mode[0];
						end else if (state.count_value == MAX) begin
							next_state.wave_output = ~state.compare_out_mode[0];
						end
					end
				end
				default: begin
					if (state.compare_out_mode[1]) begin
						if (!state.count_down && state.count_value == MAX) begin
							// at TOP take the up-match result
							// for the value loaded now, so no match is missed
							if (state.compare_value == MAX) begin
								next_state.wave_output = ~state.compare_out_mode[0];
							end else begin
								next_state.wave_output = state.compare_out_mode[0];
							end
						end else if (match && active_cmp != MAX) begin
							// clear up / set down, setting 3 inverse
							// A match at BOTTOM belongs to the up slope, so zero stays low in setting 2, high in setting 3
							next_state.wave_output =
								(state.count_down && state.count_value != BOTTOM) ?
								~state.compare_out_mode[0] : state.compare_out_mode[0];
						end
					end
				end
			endcase
		end

		// Register writes
		if (wr_ctrl) begin
			next_state.wave_mode_low = wdata_in[MODE_LOW_BIT];
			next_state.compare_out_mode = wdata_in[OUT_MODE_HI:OUT_MODE_LO];
			next_state.wave_mode_high = wdata_in[MODE_HIGH_BIT];
			next_state.clock_source_sel = wdata_in[CLK_SEL_HI:0];
			// forced compare, non-PWM only, no flag or clear
			if (wdata_in[FORCE_BIT] && !wdata_in[MODE_LOW_BIT]) begin
				next_state.wave_output = match_level(wdata_in[OUT_MODE_HI:OUT_MODE_LO],
					state.wave_output);
			end
		end
		if (wr_count) begin
			next_state.count_value = wdata_in;
			next_state.block_match = 1'b1;
		end
		if (wr_cmp) begin
			next_state.compare_value = wdata_in;
			if (!is_pwm) begin
				next_state.compare_buffer = wdata_in;
			end
		end
		// Write one clears; a same-cycle hardware set wins
		if (wr_flags) begin
			if (wdata_in[FLAG_OVF_BIT] && !ovf_set) begin
				next_state.overflow_flag = 1'b0;
			end
			if (wdata_in[FLAG_CMP_BIT] && !(timer_tick && match)) begin
				next_state.compare_match_flag = 1'b0;
			end
		end

		// Read data stand only in the cycle after the strobe
		next_state.rdata = 8'h00;
		if (read_in) begin
			if (addr_in == REG_CONTROL_A) begin
				next_state.rdata = {1'b0, state.wave_mode_low, state.compare_out_mode,
					state.wave_mode_high, state.clock_source_sel};
			end else if (addr_in == REG_COUNT) begin
				next_state.rdata = state.count_value;
			end else if (addr_in == REG_COMPARE) begin
				next_state.rdata = state.compare_value;
			end else begin
				next_state.rdata = {6'h00, state.compare_match_flag, state.overflow_flag};
			end
		end

		// pin driven only with output direction and a connected mode
		next_state.pin = next_state.wave_output;
		next_state.pin_oe = pin_dir_out_in && (next_state.compare_out_mode != 2'h0);
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= '0;
			state.count_value <= COUNT_RESET;
			state.compare_value <= COMPARE_RESET;
			state.compare_buffer <= COMPARE_RESET;
			{state.wave_mode_low, state.compare_out_mode, state.wave_mode_high,
				state.clock_source_sel} <= CONTROL_A_RESET[6:0];
		end else begin
			state <= next_state;
		end
	end

	assign rdata_out = state.rdata;
	assign wave_output_pin_out = state.pin;
	assign wave_output_pin_oe_out = state.pin_oe;
	assign overflow_flag_out = state.overflow_flag;
	assign compare_match_flag_out = state.compare_match_flag;
endmodule

/* inc/timer8_pkg.sv */
// Constants and types for the 8-bit waveform timer
package timer8_pkg;
	// Register indices (word offsets on the plain port)
	localparam logic [1:0] REG_CONTROL_A = 2'h0;
	localparam logic [1:0] REG_COUNT = 2'h1;
	localparam logic [1:0] REG_COMPARE = 2'h2;
	localparam logic [1:0] REG_FLAGS = 2'h3;
	// Control register A field positions
	localparam int FORCE_BIT = 7;
	localparam int MODE_LOW_BIT = 6;
	localparam int OUT_MODE_HI = 5;
	localparam int OUT_MODE_LO = 4;
	localparam int MODE_HIGH_BIT = 3;
	localparam int CLK_SEL_HI = 2;
	// Flag register bit positions
	localparam int FLAG_OVF_BIT = 0;
	localparam int FLAG_CMP_BIT = 1;
	// Reset values
	localparam logic [7:0] CONTROL_A_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COMPARE_RESET = 8'h00;
	// Counter limits
	localparam logic [7:0] BOTTOM = 8'h00;
	localparam logic [7:0] MAX = 8'hFF;
	// Prescale factors
	localparam int PRESCALE_8 = 8;
	localparam int PRESCALE_64 = 64;
	localparam int PRESCALE_256 = 256;
	localparam int PRESCALE_1024 = 1024;
	localparam logic [9:0] PRESCALE_LAST = 10'(PRESCALE_1024 - 1);
	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_PHASE_PWM,
		MODE_CLEAR_ON_MATCH,
		MODE_FAST_PWM
	} wave_mode_t;
endpackage

/* design/timer8_prescaler.sv */
// Prescaler and clock source selection producing the timer tick
`timescale 1ns/1ns
module timer8_prescaler (
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Selection and external source
	input wire logic [2:0] clock_source_sel_in,
	input wire logic ext_clock_in,
	// Tick out
	output logic timer_tick_out
);
	import timer8_pkg::*;

	typedef struct packed {
		logic [9:0] div;
		logic ext_prev;
		logic tick;
	} presc_state_t;

	presc_state_t state;
	presc_state_t next_state;

	function automatic logic div_hit(input logic [9:0] d, input int n);
		div_hit = (d & 10'(n - 1)) == 10'(n - 1);
	endfunction

	always_comb begin
		next_state = state;
		next_state.div = state.div + 10'h001;
		next_state.ext_prev = ext_clock_in;
		case (clock_source_sel_in)
			3'h1: next_state.tick = 1'b1;
			3'h2: next_state.tick = div_hit(state.div, PRESCALE_8);
			3'h3: next_state.tick = div_hit(state.div, PRESCALE_64);
			3'h4: next_state.tick = div_hit(state.div, PRESCALE_256);
			3'h5: next_state.tick = div_hit(state.div, PRESCALE_1024);
			3'h6: next_state.tick = state.ext_prev & ~ext_clock_in;
			3'h7: next_state.tick = ~state.ext_prev & ext_clock_in;
			default: next_state.tick = 1'b0;
		endcase
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign timer_tick_out = state.tick;
endmodule

/* sim/timer8_wave_monitor.sv */
// Port checker for the 8-bit waveform timer
`timescale 1ns/1ns
module timer8_wave_monitor import timer8_pkg::*; (
	// Clock and reset
	input wire logic clock_in,
	input wire logic arst_n_in,
	// Register port
	input wire logic [1:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	input wire logic [7:0] rdata_out,
	// Pins and flags
	input wire logic ext_clock_in,
	input wire logic pin_dir_out_in,
	input wire logic wave_output_pin_out,
	input wire logic wave_output_pin_oe_out,
	input wire logic overflow_flag_out,
	input wire logic compare_match_flag_out
);
	logic [7:0] ctl;
	logic ctl_wr;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);
	assign ctl_wr = write_in && addr_in == REG_CONTROL_A;
	// Shadow of control A; the strobe bit is never stored
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in)
			ctl <= 8'h00;
		else if (ctl_wr)
			ctl <= wdata_in & 8'h7F;
	end
	property p_rd_idle; !$past(read_in) |-> rdata_out == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_ctl_rd; $past(read_in) && $past(addr_in) == REG_CONTROL_A |-> rdata_out == $past(ctl);
	endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
	property p_force_rd; $past(read_in) |-> !rdata_out[FORCE_BIT] || $past(addr_in) != 2'h0;
	endproperty
	a_force_rd: assert property (p_force_rd) else $error("strobe bit read as one");
	property p_oe_dir; wave_output_pin_oe_out |-> $past(pin_dir_out_in); endproperty
	a_oe_dir: assert property (p_oe_dir) else $error("pin driven as input");
	property p_oe_off; ctl[5:4] == 2'h0 && $past(ctl[5:4]) == 2'h0 |-> !wave_output_pin_oe_out;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin driven when off");
	property p_ovf_clr; $fell(overflow_flag_out) |-> $past(write_in && addr_in == REG_FLAGS
		&& wdata_in[FLAG_OVF_BIT]); endproperty
	a_ovf_clr: assert property (p_ovf_clr) else $error("overflow flag lost");
	property p_cmp_clr; $fell(compare_match_flag_out) |-> $past(write_in && addr_in == REG_FLAGS
		&& wdata_in[FLAG_CMP_BIT]); endproperty
	a_cmp_clr: assert property (p_cmp_clr) else $error("compare flag lost");
	property p_stop; ctl[2:0] == 3'h0 && $past(ctl[2:0]) == 3'h0 && $past(ctl[2:0], 2) == 3'h0
		|-> !$rose(overflow_flag_out) && !$rose(compare_match_flag_out); endproperty
	a_stop: assert property (p_stop) else $error("flag set while stopped");
	property p_force_set; ctl_wr && wdata_in == 8'hB0 && pin_dir_out_in
		|-> ##[1:2] wave_output_pin_out; endproperty
	a_force_set: assert property (p_force_set) else $error("forced set missing");
endmodule
bind timer8_wave timer8_wave_monitor u_timer8_wave_monitor (.clock_in(clock_in),
	.arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
	.read_in(read_in), .rdata_out(rdata_out), .ext_clock_in(ext_clock_in),
	.pin_dir_out_in(pin_dir_out_in), .wave_output_pin_out(wave_output_pin_out),
	.wave_output_pin_oe_out(wave_output_pin_oe_out), .overflow_flag_out(overflow_flag_out),
	.compare_match_flag_out(compare_match_flag_out));

/* sim/tb_top.sv */
// Self-checking bench for the 8-bit waveform timer
`timescale 1ns/1ns
module tb_top;
	import timer8_pkg::*;
	logic clock_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [1:0] addr_in = 2'h0;
	logic [7:0] wdata_in = 8'h00;
	logic write_in = 1'b0;
	logic read_in = 1'b0;
	logic ext_clock_in = 1'b0;
	logic pin_dir_out_in = 1'b1;
	logic [7:0] rdata_out;
	logic wave_output_pin_out;
	logic wave_output_pin_oe_out;
	logic overflow_flag_out;
	logic compare_match_flag_out;
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;
	int w;
	logic [7:0] c;
	logic [7:0] r;
	logic [15:0] hi;
	logic [15:0] oe;
	logic [15:0] n;
	logic [7:0] cv [3];
	logic [2:0] ss [4] = '{3'h1, 3'h2, 3'h7, 3'h6};
	int fs [4] = '{1, 8, 4, 4};
	logic [1:0] md [3] = '{2'h0, 2'h3, 2'h2};
	timer8_wave u_timer8_wave (.clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
		.ext_clock_in(ext_clock_in), .pin_dir_out_in(pin_dir_out_in),
		.wave_output_pin_out(wave_output_pin_out), .wave_output_pin_oe_out(wave_output_pin_oe_out),
		.overflow_flag_out(overflow_flag_out), .compare_match_flag_out(compare_match_flag_out));
	always #10 clock_in = ~clock_in;
	task automatic close_out();
		if (error_cnt == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// External source rises every fourth cycle
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		ext_clock_in <= cycles[1];
		if (cycles == 80000) begin
			error_cnt++;
			close_out();
		end
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		write_in <= 1'b1;
		@(posedge clock_in);
		write_in <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clock_in);
		addr_in <= a;
		read_in <= 1'b1;
		@(posedge clock_in);
		read_in <= 1'b0;
		#1 d = rdata_out;
	endtask
	function automatic logic [7:0] ctl(input logic [1:0] m, input logic [1:0] o,
		input logic [2:0] s);
		return {1'b0, m[0], o, m[1], s};
	endfunction
	// High time of one phase PWM period
	function automatic logic [15:0] exp_hi(input logic [7:0] v, input bit inv);
		return inv ? 16'h01FE - {7'h00, v, 1'b0} : {7'h00, v, 1'b0};
	endfunction
	task automatic meas(input int len);
		hi = 16'h0000;
		oe = 16'h0000;
		repeat (len) begin
			@(posedge clock_in);
			#1;
			hi = hi + 16'(wave_output_pin_out);
			oe = oe + 16'(wave_output_pin_oe_out);
		end
	endtask
	task automatic wait_ovf();
		do begin
			@(posedge clock_in);
			#1;
		end while (overflow_flag_out !== 1'b1);
	endtask
	task automatic period(output logic [15:0] len);
		int t0;
		wr(REG_FLAGS, 8'h03);
		wait_ovf();
		t0 = cycles;
		wr(REG_FLAGS, 8'h03);
		wait_ovf();
		len = 16'(cycles - t0);
	endtask
	initial begin
		c = 8'($urandom(32'hb208));
		repeat (8) @(posedge clock_in);
		arst_n_in <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			rd(2'(i), r);
			chk({8'h00, r}, 16'h0000);
		end
		wr(REG_COMPARE, c);
		rd(REG_COMPARE, r);
		chk({8'h00, r}, {8'h00, c});
		// Stopped counter, forced compares
		wr(REG_CONTROL_A, 8'h80 | ctl(2'h0, 2'h3, 3'h0));
		rd(REG_CONTROL_A, r);
		chk({8'h00, r}, {8'h00, ctl(2'h0, 2'h3, 3'h0)});
		chk({15'h0000, wave_output_pin_out}, 16'h0001);
		wr(REG_CONTROL_A, 8'h80 | ctl(2'h0, 2'h2, 3'h0));
		repeat (2) @(posedge clock_in);
		#1;
		chk({15'h0000, wave_output_pin_out}, 16'h0000);
		chk({15'h0000, compare_match_flag_out}, 16'h0000);
		wr(REG_CONTROL_A, 8'h80 | ctl(2'h3, 2'h3, 3'h0));
		repeat (2) @(posedge clock_in);
		#1;
		chk({15'h0000, wave_output_pin_out}, 16'h0000);
		// Forced toggle in clear-on-match mode must keep the count
		wr(REG_CONTROL_A, ctl(2'h2, 2'h1, 3'h0));
		wr(REG_COUNT, 8'h05);
		wr(REG_CONTROL_A, 8'h80 | ctl(2'h2, 2'h1, 3'h0));
		rd(REG_COUNT, r);
		chk({8'h00, r}, 16'h0005);
		chk({15'h0000, wave_output_pin_out}, 16'h0001);
		chk({15'h0000, compare_match_flag_out}, 16'h0000);
		@(posedge clock_in);
		pin_dir_out_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		#1;
		chk({15'h0000, wave_output_pin_oe_out}, 16'h0000);
		@(posedge clock_in);
		pin_dir_out_in <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(REG_CONTROL_A, ctl(2'h1, 2'h2, ss[i]));
			period(n);
			chk(n, 16'(510 * fs[i]));
		end
		cv = '{8'hFF, 8'($urandom_range(254, 1)), 8'h00};
		for (int k = 0; k < 6; k++) begin
			wr(REG_CONTROL_A, ctl(2'h1, 2'(2 + k / 3), 3'h1));
			wr(REG_COMPARE, cv[k % 3]);
			repeat (1100) @(posedge clock_in);
			meas(510);
			chk(hi, exp_hi(cv[k % 3], k >= 3));
			chk(oe, 16'h01FE);
		end
		c = 8'($urandom_range(200, 1));
		for (int i = 0; i < 3; i++) begin
			wr(REG_CONTROL_A, ctl(md[i], 2'h1, 3'h1));
			wr(REG_COMPARE, c);
			repeat (1100) @(posedge clock_in);
			w = (md[i] == 2'h2) ? 2 * (int'(c) + 1) : 512;
			meas(w);
			chk(hi, 16'(w / 2));
		end
		// Both flags are left set; the counter passes MAX in the normal and fast PWM runs
		rd(REG_FLAGS, r);
		chk({8'h00, r}, 16'h0003);
		wr(REG_FLAGS, 8'h01);
		rd(REG_FLAGS, r);
		chk({8'h00, r}, 16'h0002);
		close_out();
	end
endmodule
